// *** frps_defines.svh ***
// Timing constants and rule summary for the four-rail power sequencer
// Summary of operation
// - Reset state: all outputs low
// - Main rail high 190 ms enables first
// - Main and second high 30 us
// - Main and third high 30 us
// - All four high 190 ms gives good
// - Fixed output pattern per state
// - Secondary fault drops only power-good
// - Main fault in the power-good state drops everything immediately
// - Power-good latches monitoring mode
// - Enables do not follow their rail inputs; they clear only on a main fault in the power-good state
// - Power-good implies all three enables
`ifndef FRPS_DEFINES_SVH
`define FRPS_DEFINES_SVH
`define FRPS_CLK_HZ      100000000
`define FRPS_LONG_MS     190
`define FRPS_SHORT_US    30
`define FRPS_LONG_CYC    ((`FRPS_CLK_HZ / 1000) * `FRPS_LONG_MS)
`define FRPS_SHORT_CYC   ((`FRPS_CLK_HZ / 1000000) * `FRPS_SHORT_US)
`define FRPS_CNT_W       25
`endif

// *** frps_pkg.sv ***
// Types shared by the four-rail power sequencer
`default_nettype none
package frps_pkg;
  typedef enum logic [2:0] {
    FRPS_RESET = 3'h0,
    FRPS_EN1   = 3'h1,
    FRPS_EN2   = 3'h2,
    FRPS_EN3   = 3'h3,
    FRPS_GOOD  = 3'h4
  } frps_state_e;

  typedef struct packed {
    logic main_rail_ok;
    logic second_rail_ok;
    logic third_rail_ok;
    logic final_rail_ok;
  } frps_rails_s;

  typedef struct packed {
    logic first_regulator_enable;
    logic second_regulator_enable;
    logic third_regulator_enable;
    logic all_rails_good;
  } frps_outs_s;
endpackage
`default_nettype wire

// *** frps_qual_timer.sv ***
// Qualification timer: reports a condition held for a programmed count
`default_nettype none
module frps_qual_timer
  import frps_pkg::*;
#(
  parameter int W = 25
)(
  input  wire logic         clock,   // System clock
  input  wire logic         rst,     // Async reset
  input  wire logic         cond,    // Condition to qualify
  input  wire logic [W-1:0] limit,   // Cycles required
  output logic              done     // Condition held long enough
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  // Count while held, saturate at limit, clear on drop
  always_comb
  begin
    if (!cond)
      cnt_d = '0;
    else if (cnt_q < limit)
      cnt_d = cnt_q + W'(1);
    else
      cnt_d = cnt_q;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end

  assign done = cond && (cnt_q >= limit - W'(1));

  p_restart: assert property (@(posedge clock) disable iff (rst)
    !cond |=> cnt_q == '0) else $error("timer did not restart");
endmodule
`default_nettype wire

// *** frps_sequencer.sv ***
// Four-rail power sequencer core
`include "frps_defines.svh"
`default_nettype none
module frps_sequencer
  import frps_pkg::*;
#(
  parameter int                       CNT_W      = `FRPS_CNT_W,
  parameter logic [`FRPS_CNT_W-1:0]   LONG_CYC   = `FRPS_CNT_W'(`FRPS_LONG_CYC),
  parameter logic [`FRPS_CNT_W-1:0]   SHORT_CYC  = `FRPS_CNT_W'(`FRPS_SHORT_CYC)
)(
  input  wire logic clock,                    // 100 MHz system clock
  input  wire logic rst,                      // Async reset, active high
  input  wire logic main_rail_ok,             // Comparator 1, async
  input  wire logic second_rail_ok,           // Comparator 2, async
  input  wire logic third_rail_ok,            // Comparator 3, async
  input  wire logic final_rail_ok,            // Comparator 4, async
  output logic      first_regulator_enable,   // Regulator 1 enable
  output logic      second_regulator_enable,  // Regulator 2 enable
  output logic      third_regulator_enable,   // Regulator 3 enable
  output logic      all_rails_good            // Power-good
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers, comparators are asynchronous to the clock
  frps_rails_s meta_q;
  frps_rails_s sync_q;
  frps_rails_s meta_d;
  frps_rails_s sync_d;

  always_comb
  begin
    meta_d = '{main_rail_ok, second_rail_ok, third_rail_ok, final_rail_ok};
    sync_d = meta_q;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One timer shared by all states; condition chosen by state
  frps_state_e      state_q;
  frps_state_e      state_d;
  frps_outs_s       outs_q;
  frps_outs_s       outs_d;
  logic             tmr_cond;
  logic [CNT_W-1:0] tmr_limit;
  logic             tmr_done;
  logic             main_fault;
  logic             entered_q;
  logic             entered_d;

  // Enable x is confirmed by input x+1 in the board wiring
  always_comb
  begin
    tmr_cond  = 1'b0;
    tmr_limit = SHORT_CYC;
    case (state_q)
      FRPS_RESET:
      begin
        tmr_cond  = sync_q.main_rail_ok;
        tmr_limit = LONG_CYC;
      end
      FRPS_EN1:
        tmr_cond = sync_q.main_rail_ok && sync_q.second_rail_ok;
      FRPS_EN2:
        tmr_cond = sync_q.main_rail_ok && sync_q.third_rail_ok;
      FRPS_EN3:
      begin
        tmr_cond  = &sync_q;
        tmr_limit = LONG_CYC;
      end
      FRPS_GOOD:
        // Secondary rail low is the qualified condition here
        tmr_cond = !(sync_q.second_rail_ok && sync_q.third_rail_ok && sync_q.final_rail_ok);
      default:
        tmr_cond = 1'b0;
    endcase
    // Fresh count on state entry; the old count may still be saturated
    if (entered_q)
      tmr_cond = 1'b0;
  end

  frps_qual_timer #(
    .W (CNT_W)
  ) u_timer (
    .clock (clock),
    .rst   (rst),
    .cond  (tmr_cond),
    .limit (tmr_limit),
    .done  (tmr_done)
  );

  // Main-rail fault acts at once in the good state, without qualification
  assign main_fault = !sync_q.main_rail_ok;

  ////////////////////////////////////////////////////////////////////////////
  // First cycle of each state
  // The shared counter may still hold the count of the state just left while
  // the new condition is already true; masking the condition for one cycle
  // makes every step count afresh from zero, at the cost of one cycle.
  always_comb
  begin
    entered_d = (state_d != state_q);
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      entered_q <= 1'b0;
    else
      entered_q <= entered_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing state machine
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      FRPS_RESET:
        if (tmr_done)
          state_d = FRPS_EN1;
      FRPS_EN1:
        if (tmr_done)
          state_d = FRPS_EN2;
      FRPS_EN2:
        if (tmr_done)
          state_d = FRPS_EN3;
      FRPS_EN3:
        if (tmr_done)
          state_d = FRPS_GOOD;
      FRPS_GOOD:
        // Latched monitoring: enables no longer track their inputs
        if (main_fault)
          state_d = FRPS_RESET;
        else if (tmr_done)
          state_d = FRPS_EN3;
      default:
        state_d = FRPS_RESET;
    endcase
  end

  // Outputs decoded from next state so they move with the state
  always_comb
  begin
    outs_d = '0;
    case (state_d)
      FRPS_RESET: outs_d = '0;
      FRPS_EN1:   outs_d = 4'h8;
      FRPS_EN2:   outs_d = 4'hC;
      FRPS_EN3:   outs_d = 4'hE;
      FRPS_GOOD:  outs_d = 4'hF;
      default:    outs_d = '0;
    endcase
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_q <= FRPS_RESET;
      outs_q  <= '0;
    end
    else
    begin
      state_q <= state_d;
      outs_q  <= outs_d;
    end
  end

  assign first_regulator_enable  = outs_q.first_regulator_enable;
  assign second_regulator_enable = outs_q.second_regulator_enable;
  assign third_regulator_enable  = outs_q.third_regulator_enable;
  assign all_rails_good          = outs_q.all_rails_good;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  p_reset_low: assert property (@(posedge clock) disable iff (rst)
    state_q == FRPS_RESET |-> outs_q == '0) else $error("outputs high in reset state");
  p_first_needs_main: assert property (@(posedge clock) disable iff (rst)
    $rose(first_regulator_enable) |-> $past(sync_q.main_rail_ok)) else $error("first enable without main");
  p_second_step: assert property (@(posedge clock) disable iff (rst)
    $rose(second_regulator_enable) |-> $past(state_q) == FRPS_EN1 && $past(sync_q.second_rail_ok))
    else $error("second enable out of order");
  p_third_step: assert property (@(posedge clock) disable iff (rst)
    $rose(third_regulator_enable) && $past(state_q) != FRPS_GOOD |-> $past(sync_q.third_rail_ok))
    else $error("third enable without third rail");
  p_good_needs_all: assert property (@(posedge clock) disable iff (rst)
    $rose(all_rails_good) |-> $past(&sync_q) && $past(state_q) == FRPS_EN3)
    else $error("power-good without all rails");
  p_pattern: assert property (@(posedge clock) disable iff (rst)
    state_q == FRPS_EN2 |-> outs_q == 4'hC) else $error("bad output pattern");
  p_secondary_fault: assert property (@(posedge clock) disable iff (rst)
    state_q == FRPS_GOOD && sync_q.main_rail_ok && !sync_q.final_rail_ok
      && !$past(sync_q.final_rail_ok) ##1 state_q == FRPS_EN3
    |-> third_regulator_enable && !all_rails_good) else $error("secondary fault dropped enables");
  p_main_fault: assert property (@(posedge clock) disable iff (rst)
    state_q == FRPS_GOOD && !sync_q.main_rail_ok |=> outs_q == '0) else $error("main fault not immediate");
  p_good_and: assert property (@(posedge clock) disable iff (rst)
    all_rails_good |-> first_regulator_enable && second_regulator_enable && third_regulator_enable)
    else $error("power-good without enables");
  p_restart: assert property (@(posedge clock) disable iff (rst)
    state_q == FRPS_GOOD && !sync_q.main_rail_ok |=> state_q == FRPS_RESET) else $error("no restart");

  ////////////////////////////////////////////////////////////////////////////
  // Check helpers: run lengths of the qualifying inputs
  // Counted apart from the timer, so a timer that fires early is caught
  logic [CNT_W-1:0] main_run_q;
  logic [CNT_W-1:0] main_run_d;
  logic [CNT_W-1:0] all_run_q;
  logic [CNT_W-1:0] all_run_d;

  // Saturating run counters, cleared whenever the input drops
  always_comb
  begin
    main_run_d = main_run_q;
    all_run_d  = all_run_q;
    if (!sync_q.main_rail_ok)
      main_run_d = '0;
    else if (main_run_q != '1)
      main_run_d = main_run_q + CNT_W'(1);
    if (!(&sync_q))
      all_run_d = '0;
    else if (all_run_q != '1)
      all_run_d = all_run_q + CNT_W'(1);
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      main_run_q <= '0;
      all_run_q  <= '0;
    end
    else
    begin
      main_run_q <= main_run_d;
      all_run_q  <= all_run_d;
    end
  end

  // First enable only after a full long run of the main rail
  a_first_long: assert property (@(posedge clock) disable iff (rst)
    $rose(first_regulator_enable) |-> $past(main_run_q) >= LONG_CYC - CNT_W'(1))
    else $error("first enable before long hold");

  // Power-good only after a full long run of all four rails
  a_good_long: assert property (@(posedge clock) disable iff (rst)
    $rose(all_rails_good) |-> $past(all_run_q) >= LONG_CYC - CNT_W'(1))
    else $error("power-good before long hold");

  // No step on the first cycle of a state; only the main fault may act
  a_entry_fresh: assert property (@(posedge clock) disable iff (rst)
    entered_q && state_q != FRPS_GOOD |-> state_d == state_q)
    else $error("step taken on state entry");

  // Remaining output patterns
  a_en1_pattern: assert property (@(posedge clock) disable iff (rst)
    state_q == FRPS_EN1 |-> outs_q == 4'h8) else $error("bad first-enable pattern");
  a_en3_pattern: assert property (@(posedge clock) disable iff (rst)
    state_q == FRPS_EN3 |-> outs_q == 4'hE) else $error("bad third-enable pattern");
  a_good_pattern: assert property (@(posedge clock) disable iff (rst)
    state_q == FRPS_GOOD |-> outs_q == 4'hF) else $error("bad power-good pattern");

  // Power-up phase never steps back to reset
  a_no_backstep: assert property (@(posedge clock) disable iff (rst)
    state_q != FRPS_RESET && state_q != FRPS_GOOD |=> state_q != FRPS_RESET)
    else $error("stepped back during power-up");

  // Monitoring mode keeps the enables while the main rail holds
  a_monitor_hold: assert property (@(posedge clock) disable iff (rst)
    state_q == FRPS_GOOD && sync_q.main_rail_ok |=> third_regulator_enable)
    else $error("enable dropped in monitoring mode");

  // Qualified secondary fault leaves only power-good low
  a_secondary_exit: assert property (@(posedge clock) disable iff (rst)
    state_q == FRPS_GOOD && sync_q.main_rail_ok && tmr_done |=> state_q == FRPS_EN3 && !all_rails_good)
    else $error("secondary fault not taken");

  // Reset state waits while the main rail is low
  a_main_wait: assert property (@(posedge clock) disable iff (rst)
    state_q == FRPS_RESET && !sync_q.main_rail_ok |=> state_q == FRPS_RESET && outs_q == '0)
    else $error("left reset without main rail");

  // Second stage only copies the first
  a_sync_chain: assert property (@(posedge clock) disable iff (rst)
    sync_q == $past(meta_q)) else $error("synchroniser skipped a stage");

  // Power-good falls only by leaving the good state
  a_good_fall: assert property (@(posedge clock) disable iff (rst)
    $fell(all_rails_good) |-> $past(state_q) == FRPS_GOOD && state_q != FRPS_GOOD)
    else $error("power-good fell while still good");

  // First enable falls only on the way back to reset
  a_reset_fall: assert property (@(posedge clock) disable iff (rst)
    $fell(first_regulator_enable) |-> state_q == FRPS_RESET)
    else $error("first enable fell outside reset");
endmodule
`default_nettype wire

// *** frps_rail_model.sv ***
// Behavioural rails, regulators and main supply around the sequencer
`default_nettype none
module frps_rail_model
  import frps_pkg::*;
#(
  parameter int DLY = 4
)(
  input  wire logic       clock,     // System clock
  input  wire logic       rst,       // Async reset
  input  wire logic       main_cmd,  // Logic level on main input
  input  wire logic       slow,      // Slow regulator ramp
  input  wire logic [2:0] drop,      // Forced faults, rail 2 at top
  input  wire logic [2:0] en,        // Enables, first at top
  output var frps_rails_s rails      // Comparator results
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DLY-1:0] r2_q, r3_q, r4_q;
  ////////////////////////////////////////
  // Ramp pipelines, one per switched rail
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      {r2_q, r3_q, r4_q} <= '0;
    else
      {r2_q, r3_q, r4_q} <= {r2_q[DLY-2:0], en[2], r3_q[DLY-2:0], en[1], r4_q[DLY-2:0], en[0]};
  end
  // Enable x seen on input x+1; main driven as plain logic
  assign rails = {main_cmd,
                  (slow ? r2_q[DLY-1] : r2_q[0]) & ~drop[2],
                  (slow ? r3_q[DLY-1] : r3_q[0]) & ~drop[1],
                  (slow ? r4_q[DLY-1] : r4_q[0]) & ~drop[0]};
endmodule
`default_nettype wire

// *** frps_sequencer_tb_top.sv ***
// Self-checking bench for the four-rail power sequencer
`default_nettype none
module frps_sequencer_tb_top
  import frps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LONG  = 40;
  localparam int SHORT = 8;
  logic        clock, rst, main_cmd, slow;
  logic [2:0]  drop;
  logic [31:0] seed;
  frps_rails_s rails;
  frps_outs_s  outs;
  int          failures, checked, i, n;
  ////////////////////////////////////////
  frps_rail_model #(.DLY(4)) partner (.clock(clock), .rst(rst), .main_cmd(main_cmd), .slow(slow),
    .drop(drop), .en(outs[3:1]), .rails(rails));
  frps_sequencer #(.LONG_CYC(25'(LONG)), .SHORT_CYC(25'(SHORT))) uut (.clock(clock), .rst(rst),
    .main_rail_ok(rails.main_rail_ok), .second_rail_ok(rails.second_rail_ok),
    .third_rail_ok(rails.third_rail_ok), .final_rail_ok(rails.final_rail_ok),
    .first_regulator_enable(outs.first_regulator_enable),
    .second_regulator_enable(outs.second_regulator_enable),
    .third_regulator_enable(outs.third_regulator_enable), .all_rails_good(outs.all_rails_good));
  ////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Output pattern of state 1 to 5
  function automatic logic [3:0] pat(input int st);
    return {st > 1, st > 2, st > 3, st > 4};
  endfunction
  task automatic chk(input string what, input logic [3:0] exp);
    checked++;
    if (outs !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, outs);
    end
  endtask
  task automatic chkn(input string what, input int lo, input int hi, input int got);
    checked++;
    if (got < lo || got > hi)
    begin
      failures++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  // Bounded wait; looks 1 ns after the edge, once the outputs have settled
  task automatic wait_pat(input int st, input int lim, output int took);
    took = 0;
    while (outs !== pat(st) && took < lim)
    begin
      @(posedge clock);
      #1;
      took++;
    end
  endtask
  task automatic wrap_up();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////
  // Free-running 100 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Watchdog, well past the expected thousand or so cycles
  initial
  begin
    #100us;
    failures++;
    wrap_up();
  end
  // Main sequence: glitches, then three power cycles
  initial
  begin
    {rst, main_cmd, slow, drop} = 6'h20;
    seed = 32'h34ECFF91;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    chk("reset outputs", pat(1));
    for (i = 0; i < 6; i++)
    begin
      seed = lfsr(seed);
      main_cmd <= 1'b1;
      repeat (1 + seed[4:0] % 30) @(posedge clock);
      main_cmd <= 1'b0;
      repeat (3) @(posedge clock);
    end
    chk("glitches ignored", pat(1));
    for (i = 0; i < 3; i++)
    begin
      slow <= i[0];
      main_cmd <= 1'b1;
      wait_pat(2, 100, n);
      chk("first step", pat(2));
      chkn("first delay", LONG, LONG + 4, n);
      wait_pat(3, 100, n);
      chk("second step", pat(3));
      wait_pat(4, 100, n);
      chk("third step", pat(4));
      wait_pat(5, 200, n);
      chk("power good", pat(5));
      chkn("good delay", LONG, LONG + 10, n);
      // Fault shorter than the short count
      seed = lfsr(seed);
      drop <= 3'h4 >> i;
      repeat (1 + seed[1:0]) @(posedge clock);
      drop <= 3'h0;
      repeat (SHORT) @(posedge clock);
      chk("short fault", pat(5));
      drop <= 3'h4 >> i;
      wait_pat(4, SHORT + 6, n);
      chk("secondary fault", pat(4));
      chkn("secondary delay", SHORT, SHORT + 4, n);
      drop <= 3'h0;
      wait_pat(5, 100, n);
      chk("good again", pat(5));
      main_cmd <= 1'b0;
      wait_pat(1, 4, n);
      chk("main fault", pat(1));
      chkn("main delay", 1, 3, n);
      repeat (LONG) @(posedge clock);
      chk("back in reset", pat(1));
    end
    wrap_up();
  end
endmodule
`default_nettype wire
